// File: lp_pkg.sv
`default_nettype none
package lp_pkg;
	// ==========================================
	// Clock and timing
	localparam int CLK_NS        = 4;
	localparam int WORD_GAP_NS   = 1000;
	localparam int WORD_GAP_CYC  = (WORD_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUF_WORDS     = 68;

	// ==========================================
	// Channel address fields and director codes
	localparam int EQ_LO         = 7;
	localparam int EQ_HI         = 10;
	localparam int W_LO          = 11;
	localparam int W_HI          = 15;
	localparam logic [1:0] D_DATA  = 2'h0;
	localparam logic [1:0] D_FUNC1 = 2'h1;
	localparam logic [1:0] D_FUNC2 = 2'h3;

	// ==========================================
	// Director function 1 bits
	localparam int F1_CLR        = 0;
	localparam int F1_CLR_INT    = 1;
	localparam int F1_EN_DATA    = 2;
	localparam int F1_EN_EOP     = 3;
	localparam int F1_EN_ALARM   = 4;

	// ==========================================
	// Director function 2 bits
	localparam int F2_PRINT      = 0;
	localparam int F2_SINGLE     = 1;
	localparam int F2_DOUBLE     = 2;
	localparam int F2_TAPE_LO    = 3;
	localparam int F2_TAPE_HI    = 14;
	localparam int F2_PITCH8     = 15;
	localparam int TAPE_LEVELS   = 12;
	localparam int LVL_TOP       = 0;
	localparam int LVL_LAST      = 11;

	// ==========================================
	// Status word bits
	localparam int ST_READY      = 0;
	localparam int ST_BUSY       = 1;
	localparam int ST_INT        = 2;
	localparam int ST_DATA       = 3;
	localparam int ST_EOP        = 4;
	localparam int ST_ALARM      = 5;
	localparam int ST_PROT       = 7;
	localparam int ST_COINC      = 9;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// ==========================================
	// Character codes
	localparam logic [6:0] CODE_BLANK = 7'h20;
	localparam logic [6:0] CODE_LAST  = 7'h5f;
	localparam logic [6:0] ROW_OFFSET = 7'h1f;

	// ==========================================
	// Paper motion states, Gray except the wait-to-idle return
	typedef enum logic [1:0] {
		M_IDLE = 2'h0,
		M_STEP = 2'h1,
		M_WAIT = 2'h3
	} motion_e;
endpackage : lp_pkg
`default_nettype wire

// File: sync_bits.sv
`default_nettype none
module sync_bits #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	if (W < 1) begin : g_bad_width
		$error("sync_bits width must be positive");
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : sync_bits
`default_nettype wire

// File: drum_row_map.sv
`default_nettype none
module drum_row_map
	import lp_pkg::*;
(
	// Character in
	input  wire logic [6:0] code,
	// Drum row out
	output logic      [6:0] row,
	output logic            legal,
	output logic            blank
);
	// Printable codes run consecutively from the blank upward
	assign legal = (code >= CODE_BLANK) && (code <= CODE_LAST);
	assign row   = legal ? code - ROW_OFFSET : 7'h00;
	assign blank = (code == CODE_BLANK);
endmodule : drum_row_map
`default_nettype wire

// File: printer_status_ctrl.sv
// What this block does
// - Status read to our equipment code gets a reply unless protect is on and protect line low.
// - Ready bit high only when all requirements met and operator made ready.
// - Busy also high from start of any paper motion until it stops.
// - Interrupt bit set whenever an interrupt response is presented.
// - Data bit shows ready for data; with data interrupt enabled, marks it.
// - While filling buffer, data bit follows not-busy per accepted word.
// - Buffer full: not-busy returns, data bit stays low, words rejected.
// - End-of-operation bit set on completion; marks enabled interrupt too.
// - Alarm bit high while any alarm condition exists.
// - Status bits six and ten to fifteen always zero.
// - Bit seven shows the protect switch state.
// - Protect on: accept only instructions with protect line high.
// - Protect off: protect line ignored, all instructions accepted.
// - Bit nine high only when pitch change causes no spacing error.
// - Characters are 7-bit codes, bit zero least significant.
// - Blank code maps to drum row one and prints nothing.
// - Print stacked with paper motion starts both together.
// - Stacked tape stops wait for farthest selected hole.
// - Second ready press drops ready after current operation ends.
// - Single-space switch advances one line even when not ready.
// - Top-of-form seeks level one hole, only with reader interlock closed.
// - Paper out: each single-cycle press allows one line until last-line hole.
// - Pitch lamps show programmed six or eight lines per inch.
`default_nettype none
module printer_status_ctrl
	import lp_pkg::*;
#(
	parameter int BUF_DEPTH = BUF_WORDS
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Channel
	input  wire logic        chan_read,
	input  wire logic        chan_write,
	input  wire logic        prot_line,
	input  wire logic [15:0] q_bus,
	input  wire logic [15:0] a_in,
	output logic      [15:0] a_out,
	output logic             reply,
	output logic             reject,
	output logic             int_out,
	// Equipment code switches
	input  wire logic [3:0]  equip_sw,
	// Operator controls
	input  wire logic        ready_sw,
	input  wire logic        space_sw,
	input  wire logic        tof_sw,
	input  wire logic        cycle_sw,
	input  wire logic        protect_sw,
	// Printer sensors
	input  wire logic        power_ok,
	input  wire logic        fuses_ok,
	input  wire logic        paper_present,
	input  wire logic        reader_closed,
	input  wire logic        drum_arm_ok,
	input  wire logic        paper_tear,
	input  wire logic        line_adv,
	input  wire logic        print_done,
	input  wire logic        pitch_coinc,
	input  wire logic [11:0] tape_hole,
	// Mechanism commands
	output logic             print_start,
	output logic             paper_step,
	output logic             buf_wr,
	output logic      [6:0]  row_hi,
	output logic      [6:0]  row_lo,
	output logic             blank_hi,
	output logic             blank_lo,
	// Lamps
	output logic             ready_lamp,
	output logic             protect_lamp,
	output logic             pitch6_lamp,
	output logic             pitch8_lamp
);
	if (BUF_DEPTH < 1 || BUF_DEPTH > 255) begin : g_bad_depth
		$error("BUF_DEPTH out of range");
	end

	// ==========================================
	// Pin synchronisers
	localparam int NS = 16 + 16 + 4 + 12 + 17;
	logic [NS-1:0] pins_s;
	logic        rd_s, wr_s, prot_s, rdy_s, sp_s, tof_s, cyc_s, psw_s;
	logic        pwr_s, fus_s, pap_s, rdr_s, arm_s, tear_s, adv_s, pdn_s, coin_s;
	logic [15:0] q_s, a_s;
	logic [3:0]  eq_s;
	logic [11:0] hole_s;

	sync_bits #(.W(NS)) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.d       ({chan_read, chan_write, prot_line, ready_sw, space_sw, tof_sw,
		           cycle_sw, protect_sw, power_ok, fuses_ok, paper_present,
		           reader_closed, drum_arm_ok, paper_tear, line_adv, print_done,
		           pitch_coinc, q_bus, a_in, equip_sw, tape_hole}),
		.q       (pins_s)
	);
	assign {rd_s, wr_s, prot_s, rdy_s, sp_s, tof_s, cyc_s, psw_s, pwr_s, fus_s,
	        pap_s, rdr_s, arm_s, tear_s, adv_s, pdn_s, coin_s, q_s, a_s, eq_s,
	        hole_s} = pins_s;

	// ==========================================
	// Edge detection of strobes and switches
	logic [7:0] prev_r;
	logic       rd_e, wr_e, rdy_e, sp_e, tof_e, cyc_e, adv_e, pdn_e;

	always_ff @(posedge sys_clk) begin
		if (rst) prev_r <= 8'h00;
		else     prev_r <= {rd_s, wr_s, rdy_s, sp_s, tof_s, cyc_s, adv_s, pdn_s};
	end
	assign {rd_e, wr_e, rdy_e, sp_e, tof_e, cyc_e, adv_e, pdn_e} =
		{rd_s, wr_s, rdy_s, sp_s, tof_s, cyc_s, adv_s, pdn_s} & ~prev_r;

	// ==========================================
	// Request decode
	function automatic logic is_cmd(input logic [15:0] q, input logic [1:0] d);
		is_cmd = (q[1:0] == d);
	endfunction : is_cmd

	logic addr_hit, prot_ok, rd_req, wr_req;
	logic st_req, dat_req, f1_req, f2_req;

	assign addr_hit = (q_s[EQ_HI:EQ_LO] == eq_s) && (q_s[W_HI:W_LO] == '0);
	assign prot_ok  = !psw_s || prot_s;
	assign rd_req   = rd_e && addr_hit;
	assign wr_req   = wr_e && addr_hit;
	assign st_req   = rd_req && q_s[0];
	assign dat_req  = wr_req && is_cmd(q_s, D_DATA);
	assign f1_req   = wr_req && is_cmd(q_s, D_FUNC1);
	assign f2_req   = wr_req && is_cmd(q_s, D_FUNC2);

	// ==========================================
	// State registers
	logic        ready_r, drop_r, print_r, eop_r, eop_irq_r, char_alm_r;
	logic        en_data_r, en_eop_r, en_alm_r, pitch8_r, credit_r, last_r;
	logic [7:0]  cnt_r;
	logic [8:0]  gap_r;
	logic [1:0]  lines_r;
	logic [11:0] mask_r, seen_r;
	motion_e     mst_r, mst_nxt;

	// ==========================================
	// Conditions
	logic reqs_ok, ready_st, moving, busy, full, data_rdy, hard_alm, alarm;
	logic alm_irq, data_irq, int_st;

	assign reqs_ok  = pwr_s && fus_s && (pap_s || credit_r) && rdr_s
	                  && arm_s && !tear_s;
	assign ready_st = ready_r && reqs_ok;
	assign moving   = (mst_r != M_IDLE);
	assign busy     = print_r || moving || (gap_r != '0);
	assign full     = (cnt_r == 8'(BUF_DEPTH));
	assign data_rdy = ready_st && !busy && !full;
	assign hard_alm = !pap_s || tear_s || !fus_s;
	assign alarm    = hard_alm || char_alm_r;
	assign alm_irq  = en_alm_r && alarm;
	assign data_irq = en_data_r && data_rdy;
	assign int_st   = alm_irq || data_irq || eop_irq_r;

	// ==========================================
	// Acceptance
	logic dat_ok, f1_ok, f2_ok, acc_dat, acc_f1, acc_f2, do_clr, do_clr_int;

	assign dat_ok  = ready_st && !full && !busy;
	assign f1_ok   = ready_st;
	assign f2_ok   = ready_st && !busy;
	assign acc_dat = dat_req && prot_ok && dat_ok;
	assign acc_f1  = f1_req && prot_ok && f1_ok;
	assign acc_f2  = f2_req && prot_ok && f2_ok;
	assign do_clr  = acc_f1 && a_s[F1_CLR] && !busy;
	assign do_clr_int = acc_f1 && (a_s[F1_CLR_INT] || a_s[F1_CLR]);

	// ==========================================
	// Character mapping of the two codes in a word
	logic [6:0] row_w [2];
	logic [1:0] legal_w, blank_w;

	for (genvar i = 0; i < 2; i++) begin : g_char
		drum_row_map u_map (
			.code  (a_s[8*i +: 7]),
			.row   (row_w[i]),
			.legal (legal_w[i]),
			.blank (blank_w[i])
		);
	end

	// ==========================================
	// Paper motion requests
	logic        op_move, sp_move, tof_move, start_mv;
	logic [1:0]  start_lines;
	logic [11:0] start_mask, seen_new;
	logic        mv_done, mv_end;

	assign op_move   = acc_f2 && (a_s[F2_SINGLE] || a_s[F2_DOUBLE]
	                   || (a_s[F2_TAPE_HI:F2_TAPE_LO] != '0));
	assign sp_move   = sp_e && pwr_s;
	assign tof_move  = tof_e && rdr_s;
	assign start_mv  = !moving && (op_move || sp_move || tof_move);
	assign start_lines = op_move ? (a_s[F2_DOUBLE] ? 2'h2 : {1'b0, a_s[F2_SINGLE]})
	                   : {1'b0, sp_move};
	assign start_mask  = op_move ? a_s[F2_TAPE_HI:F2_TAPE_LO]
	                   : (sp_move ? '0 : 12'(1 << LVL_TOP));
	assign seen_new  = seen_r | (hole_s & mask_r);
	// Farthest selected hole is the last one to pass the reader
	assign mv_done   = (lines_r <= 2'h1) && ((seen_new & mask_r) == mask_r);
	assign mv_end    = (mst_r == M_WAIT) && adv_e && mv_done;

	always_comb begin
		case (mst_r)
			M_IDLE:  mst_nxt = start_mv ? M_STEP : M_IDLE;
			M_STEP:  mst_nxt = M_WAIT;
			M_WAIT:  mst_nxt = !adv_e ? M_WAIT : (mv_done ? M_IDLE : M_STEP);
			default: mst_nxt = M_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mst_r   <= M_IDLE;
			lines_r <= 2'h0;
			mask_r  <= '0;
			seen_r  <= '0;
		end else begin
			mst_r <= mst_nxt;
			if (start_mv) begin
				lines_r <= start_lines;
				mask_r  <= start_mask;
				seen_r  <= '0;
			end else if (mst_r == M_WAIT && adv_e) begin
				lines_r <= (lines_r != 2'h0) ? lines_r - 2'h1 : 2'h0;
				seen_r  <= seen_new;
			end
		end
	end

	// ==========================================
	// Print, buffer fill and word pacing
	logic op_end, prn_go;

	assign prn_go = acc_f2 && a_s[F2_PRINT];
	assign op_end = (print_r && pdn_e) || mv_end;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			print_r <= 1'b0;
			cnt_r   <= 8'h00;
			gap_r   <= '0;
		end else begin
			if (prn_go)                 print_r <= 1'b1;
			else if (pdn_e || do_clr)   print_r <= 1'b0;
			if (pdn_e || do_clr)        cnt_r <= 8'h00;
			else if (acc_dat)           cnt_r <= cnt_r + 8'h01;
			if (acc_dat)                gap_r <= 9'(WORD_GAP_CYC);
			else if (gap_r != '0)       gap_r <= gap_r - 9'h001;
		end
	end

	// ==========================================
	// Operator ready, single cycle credit
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ready_r  <= 1'b0;
			drop_r   <= 1'b0;
			credit_r <= 1'b0;
			last_r   <= 1'b0;
		end else begin
			if (rdy_e && !ready_r && reqs_ok) ready_r <= 1'b1;
			else if (!reqs_ok || (drop_r && !busy)) ready_r <= 1'b0;
			if (rdy_e && ready_r)   drop_r <= 1'b1;
			else if (!ready_r)      drop_r <= 1'b0;
			if (pap_s)              last_r <= 1'b0;
			else if (adv_e && hole_s[LVL_LAST]) last_r <= 1'b1;
			if (cyc_e && !last_r && !pap_s) credit_r <= 1'b1;
			else if (pap_s || prn_go)       credit_r <= 1'b0;
		end
	end

	// ==========================================
	// Interrupt enables, end of operation, alarms, pitch
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			en_data_r  <= 1'b0;
			en_eop_r   <= 1'b0;
			en_alm_r   <= 1'b0;
			eop_r      <= 1'b0;
			eop_irq_r  <= 1'b0;
			char_alm_r <= 1'b0;
			pitch8_r   <= 1'b0;
		end else begin
			// Clear acts first, stacked enables then set
			if (acc_f1) begin
				en_data_r <= a_s[F1_EN_DATA] || (en_data_r && !do_clr_int);
				en_eop_r  <= a_s[F1_EN_EOP]  || (en_eop_r  && !do_clr_int);
				en_alm_r  <= a_s[F1_EN_ALARM] || (en_alm_r && !do_clr_int);
			end
			// New completion wins over a clear in the same cycle
			if (op_end)               eop_r <= 1'b1;
			else if (do_clr || acc_f2) eop_r <= 1'b0;
			if (op_end && en_eop_r)   eop_irq_r <= 1'b1;
			else if (do_clr_int)      eop_irq_r <= 1'b0;
			if (acc_dat && legal_w != 2'h3) char_alm_r <= 1'b1;
			else if (do_clr || prn_go)      char_alm_r <= 1'b0;
			if (acc_f2 && a_s[F2_PITCH8]) pitch8_r <= 1'b1;
			else if (do_clr)              pitch8_r <= 1'b0;
		end
	end

	// ==========================================
	// Status word
	logic [15:0] status_w;

	always_comb begin
		status_w           = STATUS_RESET;
		status_w[ST_READY] = ready_st;
		status_w[ST_BUSY]  = busy;
		status_w[ST_INT]   = int_st;
		status_w[ST_DATA]  = data_rdy;
		status_w[ST_EOP]   = eop_r;
		status_w[ST_ALARM] = alarm;
		status_w[ST_PROT]  = psw_s;
		status_w[ST_COINC] = coin_s;
	end

	// ==========================================
	// Channel answers and mechanism outputs
	logic any_req, any_acc;

	assign any_req = st_req || dat_req || f1_req || f2_req;
	assign any_acc = (st_req && prot_ok) || acc_dat || acc_f1 || acc_f2;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			a_out       <= STATUS_RESET;
			reply       <= 1'b0;
			reject      <= 1'b0;
			int_out     <= 1'b0;
			print_start <= 1'b0;
			paper_step  <= 1'b0;
			buf_wr      <= 1'b0;
			row_hi      <= 7'h00;
			row_lo      <= 7'h00;
			blank_hi    <= 1'b0;
			blank_lo    <= 1'b0;
		end else begin
			if (st_req && prot_ok) a_out <= status_w;
			reply       <= any_req && any_acc;
			reject      <= any_req && !any_acc;
			int_out     <= int_st;
			print_start <= prn_go;
			paper_step  <= (mst_r == M_STEP);
			buf_wr      <= acc_dat;
			if (acc_dat) begin
				row_lo   <= row_w[0];
				row_hi   <= row_w[1];
				blank_lo <= blank_w[0];
				blank_hi <= blank_w[1];
			end
		end
	end

	// ==========================================
	// Lamps
	assign ready_lamp   = ready_st;
	assign protect_lamp = psw_s;
	assign pitch6_lamp  = !pitch8_r;
	assign pitch8_lamp  = pitch8_r;
endmodule : printer_status_ctrl
`default_nettype wire

// File: printer_status_ctrl_asserts.sv
`default_nettype none
module printer_status_ctrl_asserts
	import lp_pkg::*;
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Channel
	input wire logic        prot_line,
	input wire logic [15:0] a_in,
	input wire logic [15:0] a_out,
	input wire logic        reply,
	input wire logic        reject,
	// Mechanism and lamps
	input wire logic        print_start,
	input wire logic        paper_step,
	input wire logic        buf_wr,
	input wire logic [6:0]  row_lo,
	input wire logic        blank_lo,
	input wire logic        protect_lamp,
	input wire logic        pitch6_lamp,
	input wire logic        pitch8_lamp
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Cycles since the last accepted word, saturating
	logic [8:0] gap_r;
	always_ff @(posedge sys_clk) begin
		if (rst)
			gap_r <= 9'h1ff;
		else if (buf_wr)
			gap_r <= 9'h000;
		else if (gap_r != 9'h1ff)
			gap_r <= gap_r + 9'h001;
	end

	function automatic logic [6:0] exp_row(input logic [6:0] c);
		return (c >= 7'h20 && c <= 7'h5f) ? c - 7'h1f : 7'h00;
	endfunction : exp_row

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// ==========
	// Print stacked with line motion
	sequence s_print_lines;
		print_start ##0 ($past(a_in[F2_SINGLE], 3) || $past(a_in[F2_DOUBLE], 3));
	endsequence

	reply_pulse_a: assert property (reply |=> !reply)
		else $error("reply longer than one cycle");
	answer_excl_a: assert property (!(reply && reject))
		else $error("reply and reject together");
	status_hold_a: assert property ($changed(a_out) |-> reply)
		else $error("status word changed without reply");
	unused_bits_a: assert property (a_out[6] == 1'h0 && a_out[15:10] == 6'h00)
		else $error("unused status bit set");
	pitch_lamps_a: assert property (pitch6_lamp != pitch8_lamp)
		else $error("pitch lamps not exclusive");
	blank_row_a: assert property (blank_lo |-> row_lo == 7'h01)
		else $error("blank not on row one");
	row_map_a: assert property (buf_wr |-> row_lo == exp_row($past(a_in[6:0], 3)))
		else $error("drum row wrong");
	word_reply_a: assert property (buf_wr |-> reply)
		else $error("word stored without reply");
	word_gap_a: assert property (buf_wr |-> gap_r >= 9'h0fa)
		else $error("words accepted too close");
	protect_gate_a: assert property (reply && protect_lamp |-> $past(prot_line, 2))
		else $error("unprotected instruction accepted");
	stack_start_a: assert property (s_print_lines |=> paper_step)
		else $error("stacked motion did not start");
endmodule : printer_status_ctrl_asserts
`default_nettype wire

// File: host_chan.sv
`default_nettype none
module host_chan
	import lp_pkg::*;
(
	// Clock
	input  wire logic        sys_clk,
	// Channel pins
	output logic             chan_read,
	output logic             chan_write,
	output logic             prot_line,
	output logic      [15:0] q_bus,
	output logic      [15:0] a_in,
	input  wire logic [15:0] a_out,
	input  wire logic        reply,
	input  wire logic        reject
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		chan_read = 1'h0;
		chan_write = 1'h0;
		prot_line = 1'h0;
		q_bus = 16'h0000;
		a_in = 16'h0000;
	end

	// ==========
	// One instruction; ans 1 reply, 2 reject, 0 silence
	task automatic xfer(input logic rd, input logic [15:0] q, input logic [15:0] a,
			input logic pl, output logic [1:0] ans, output logic [15:0] st);
		int n;
		ans = 2'h0;
		st = 16'h0000;
		n = 0;
		@(posedge sys_clk);
		q_bus <= q;
		a_in <= a;
		prot_line <= pl;
		repeat (3) @(posedge sys_clk);
		chan_read <= rd;
		chan_write <= !rd;
		while (ans == 2'h0 && n < 12) begin
			@(posedge sys_clk);
			n++;
			ans = {reject, reply};
			st = a_out;
		end
		chan_read <= 1'h0;
		chan_write <= 1'h0;
		q_bus <= ~q;
		a_in <= ~a;
		prot_line <= !pl;
		repeat (3) @(posedge sys_clk);
	endtask : xfer
endmodule : host_chan
`default_nettype wire

// File: tb_printer_status_ctrl.sv
`default_nettype none
module tb_printer_status_ctrl
	import lp_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] EQUIP = 4'h5;
	// ==========
	// Pins and mechanism
	logic        sys_clk = 1'h0, rst = 1'h1, pitch_coinc = 1'h0, protect_sw = 1'h0;
	logic [3:0]  sw = 4'h0;
	logic [4:0]  ok_r = 5'h1f;
	logic        line_adv = 1'h0, print_done = 1'h0, tear = 1'h0;
	logic [7:0]  adv_t = 8'h00, prt_t = 8'h00, step_n = 8'h00, base;
	logic [11:0] tape_hole = 12'h000;
	logic [11:0] tape_pat [8] = '{default: 12'h000};
	logic        chan_read, chan_write, prot_line, reply, reject, int_out, print_start;
	logic        paper_step, buf_wr, blank_hi, blank_lo, ready_lamp, protect_lamp;
	logic        pitch6_lamp, pitch8_lamp;
	logic [15:0] q_bus, a_in, a_out, stat;
	logic [6:0]  row_hi, row_lo;
	logic [1:0]  ans;
	int          err_count = 0, checked = 0, cyc = 0;

	always #2 sys_clk = ~sys_clk;

	host_chan host (.sys_clk(sys_clk), .chan_read(chan_read), .chan_write(chan_write),
		.prot_line(prot_line), .q_bus(q_bus), .a_in(a_in), .a_out(a_out), .reply(reply),
		.reject(reject));

	printer_status_ctrl #(.BUF_DEPTH(3)) DUT (.sys_clk(sys_clk), .rst(rst),
		.chan_read(chan_read), .chan_write(chan_write), .prot_line(prot_line),
		.q_bus(q_bus), .a_in(a_in), .a_out(a_out), .reply(reply), .reject(reject),
		.int_out(int_out), .equip_sw(EQUIP), .ready_sw(sw[0]), .space_sw(sw[1]),
		.tof_sw(sw[2]), .cycle_sw(sw[3]), .protect_sw(protect_sw), .power_ok(ok_r[0]),
		.fuses_ok(ok_r[1]), .paper_present(ok_r[2]), .reader_closed(ok_r[3]),
		.drum_arm_ok(ok_r[4]), .paper_tear(tear), .line_adv(line_adv),
		.print_done(print_done), .pitch_coinc(pitch_coinc), .tape_hole(tape_hole),
		.print_start(print_start), .paper_step(paper_step), .buf_wr(buf_wr),
		.row_hi(row_hi), .row_lo(row_lo), .blank_hi(blank_hi), .blank_lo(blank_lo),
		.ready_lamp(ready_lamp), .protect_lamp(protect_lamp), .pitch6_lamp(pitch6_lamp),
		.pitch8_lamp(pitch8_lamp));

	// ==========
	// Paper and drum answer some cycles after each command
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (paper_step) begin
			step_n <= step_n + 8'h01;
			tape_hole <= tape_pat[3'(step_n + 8'h01)];
			adv_t <= 8'h14;
		end else if (adv_t != 8'h00)
			adv_t <= adv_t - 8'h01;
		prt_t <= print_start ? 8'h1e : prt_t - 8'(prt_t != 8'h00);
		line_adv <= adv_t != 8'h00 && adv_t < 8'h04;
		print_done <= prt_t != 8'h00 && prt_t < 8'h04;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic op(input logic rd, input logic [1:0] d, input logic [15:0] a,
			input logic pl, input logic [1:0] e);
		host.xfer(rd, {5'h00, EQUIP, 5'h00, d}, a, pl, ans, stat);
		chk("answer", {14'h0000, e}, {14'h0000, ans});
	endtask : op

	task automatic st(input logic pl, input logic [15:0] m, input logic [15:0] e);
		op(1'h1, D_FUNC2, 16'h0000, pl, 2'h1);
		chk("status", e & m, stat & m);
	endtask : st

	task automatic press(input logic [3:0] m);
		@(posedge sys_clk);
		sw <= m;
		repeat (4) @(posedge sys_clk);
		sw <= 4'h0;
		repeat (6) @(posedge sys_clk);
	endtask : press

	task automatic test_done();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		chk("lamps", 16'h0001, {14'h0000, pitch8_lamp, pitch6_lamp});
		st(1'h0, 16'hfc41, 16'h0000);
		op(1'h0, D_FUNC2, 16'h0001, 1'h0, 2'h2);
		$display("test reset done");
		press(4'h1);
		st(1'h0, 16'h000b, 16'h0009);
		chk("ready lamp", 16'h0001, {15'h0000, ready_lamp});
		pitch_coinc <= 1'h1;
		st(1'h0, 16'h0200, 16'h0200);
		pitch_coinc <= 1'h0;
		st(1'h0, 16'h0200, 16'h0000);
		protect_sw <= 1'h1;
		repeat (5) @(posedge sys_clk);
		op(1'h1, D_FUNC2, 16'h0000, 1'h0, 2'h2);
		st(1'h1, 16'h0080, 16'h0080);
		protect_sw <= 1'h0;
		repeat (5) @(posedge sys_clk);
		st(1'h0, 16'h0080, 16'h0000);
		$display("test status done");
		op(1'h0, D_DATA, 16'h4120, 1'h0, 2'h1);
		chk("rows", 16'h2201, {1'h0, row_hi, 1'h0, row_lo});
		chk("blanks", 16'h0001, {14'h0000, blank_hi, blank_lo});
		st(1'h0, 16'h000a, 16'h0002);
		op(1'h0, D_DATA, 16'h4141, 1'h0, 2'h2);
		repeat (260) @(posedge sys_clk);
		st(1'h0, 16'h000a, 16'h0008);
		op(1'h0, D_DATA, 16'h5f7f, 1'h0, 2'h1);
		chk("rows", 16'h4000, {1'h0, row_hi, 1'h0, row_lo});
		st(1'h0, 16'h0020, 16'h0020);
		repeat (260) @(posedge sys_clk);
		op(1'h0, D_DATA, 16'h2121, 1'h0, 2'h1);
		repeat (260) @(posedge sys_clk);
		st(1'h0, 16'h000a, 16'h0000);
		op(1'h0, D_DATA, 16'h2121, 1'h0, 2'h2);
		op(1'h0, D_FUNC1, 16'h0009, 1'h0, 2'h1);
		st(1'h0, 16'h0020, 16'h0000);
		$display("test data done");
		op(1'h0, D_FUNC2, 16'h0003, 1'h0, 2'h1);
		st(1'h0, 16'h0002, 16'h0002);
		repeat (80) @(posedge sys_clk);
		st(1'h0, 16'h0016, 16'h0014);
		chk("interrupt", 16'h0001, {15'h0000, int_out});
		base = step_n;
		tape_pat[3'(base + 8'h02)] = 12'h004;
		tape_pat[3'(base + 8'h04)] = 12'h010;
		op(1'h0, D_FUNC2, 16'h00a0, 1'h0, 2'h1);
		repeat (150) @(posedge sys_clk);
		chk("steps", {8'h00, base + 8'h04}, {8'h00, step_n});
		op(1'h0, D_FUNC2, 16'h8000, 1'h0, 2'h1);
		chk("lamps", 16'h0002, {14'h0000, pitch8_lamp, pitch6_lamp});
		base = step_n;
		op(1'h0, D_FUNC2, 16'h0004, 1'h0, 2'h1);
		repeat (80) @(posedge sys_clk);
		chk("steps", {8'h00, base + 8'h02}, {8'h00, step_n});
		$display("test paper done");
		repeat (40) @(posedge sys_clk);
		press(4'h1);
		st(1'h0, 16'h0001, 16'h0000);
		base = step_n;
		press(4'h2);
		repeat (60) @(posedge sys_clk);
		chk("steps", {8'h00, base + 8'h01}, {8'h00, step_n});
		ok_r <= 5'h17;
		press(4'h4);
		repeat (60) @(posedge sys_clk);
		chk("steps", {8'h00, base + 8'h01}, {8'h00, step_n});
		ok_r <= 5'h1f;
		base = step_n;
		tape_pat[3'(base + 8'h03)] = 12'h001;
		press(4'h4);
		repeat (120) @(posedge sys_clk);
		chk("steps", {8'h00, base + 8'h03}, {8'h00, step_n});
		ok_r <= 5'h1b;
		press(4'h8);
		press(4'h1);
		st(1'h0, 16'h0021, 16'h0021);
		op(1'h0, D_FUNC1, 16'h0006, 1'h0, 2'h1);
		st(1'h0, 16'h000c, 16'h000c);
		op(1'h0, D_FUNC1, 16'h0002, 1'h0, 2'h1);
		chk("interrupt", 16'h0000, {15'h0000, int_out});
		op(1'h0, D_FUNC2, 16'h0001, 1'h0, 2'h1);
		st(1'h0, 16'h0001, 16'h0000);
		ok_r <= 5'h1f;
		tear <= 1'h1;
		st(1'h0, 16'h0020, 16'h0020);
		tear <= 1'h0;
		st(1'h0, 16'h0020, 16'h0000);
		$display("test operator done");
		test_done();
	end
endmodule : tb_printer_status_ctrl

bind printer_status_ctrl printer_status_ctrl_asserts chk_i (.sys_clk(sys_clk), .rst(rst),
	.prot_line(prot_line), .a_in(a_in), .a_out(a_out), .reply(reply), .reject(reject),
	.print_start(print_start), .paper_step(paper_step), .buf_wr(buf_wr), .row_lo(row_lo),
	.blank_lo(blank_lo), .protect_lamp(protect_lamp), .pitch6_lamp(pitch6_lamp),
	.pitch8_lamp(pitch8_lamp));
`default_nettype wire
